//--- lvm_pkg.sv
// shared constants and types for the led voltage monitor block
package lvm_pkg;
    // clock rate and delay step of the conversion delay timer
    localparam int CLK_FREQ_MHZ = 40; // system clock in MHz
    localparam int DELAY_STEP_US = 250; // one step of the start delay, in microseconds
    localparam int DELAY_STEP_CYCLES = DELAY_STEP_US * CLK_FREQ_MHZ; // cycles per step
    localparam int DELAY_CODE_W = 5; // width of the programmable delay code

    // register addresses on the register port
    localparam logic [7:0] LAST_FLASH_ADDR = 8'h0C; // last flash capture register
    localparam logic [7:0] MONITOR_ADDR = 8'h0D; // led voltage monitor register

    // monitor register field layout
    localparam int RESULT_W = 4; // conversion result width
    localparam int MON_RESULT_LSB = 0; // result field low bit
    localparam int MON_MANUAL_BIT = 4; // manual conversion enable
    localparam int MON_SHUTDOWN_BIT = 5; // converter shutdown
    localparam int MON_EOC_BIT = 6; // end of conversion flag
    localparam int MON_SPARE_BIT = 7; // unused, reads zero

    // capture register field layout
    localparam int CODE_W = 4; // flash current code width
    localparam int CAP_FIRST_LSB = 0; // first source code low bit
    localparam int CAP_SECOND_LSB = 4; // second source code low bit

    // reset values
    localparam logic [3:0] RESULT_RST = 4'h0; // result after reset
    localparam logic MANUAL_RST = 1'b0; // manual mode off
    localparam logic SHUTDOWN_RST = 1'b0; // converter enabled
    localparam logic EOC_RST = 1'b0; // done flag clear, no conversion finished yet
    localparam logic [7:0] CAPTURE_RST = 8'h00; // capture register after reset
    localparam logic [7:0] RDATA_IDLE = 8'h00; // read data for unmapped addresses

    // sequencer states
    typedef enum logic [1:0] {
        lvm_idle,
        lvm_wait,
        lvm_conv
    } lvm_state_type;
endpackage : lvm_pkg

//--- lvm_delay_timer.sv
// programmable start delay timer, counted in whole delay steps
`timescale 1ns/1ps
module lvm_delay_timer #(
    parameter int TICK_CYCLES = lvm_pkg::DELAY_STEP_CYCLES, // cycles per delay step
    parameter int CODE_WIDTH = lvm_pkg::DELAY_CODE_W // delay code width
) (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic start, // one-cycle pulse, loads the delay
    input wire logic no_delay, // skip the delay entirely
    input wire logic [CODE_WIDTH-1:0] delay_code, // steps minus one
    output logic done // one-cycle pulse when delay expires
);
    localparam int DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1; // divider width

    logic running_q; // delay in progress
    logic [DIV_W-1:0] div_q; // step divider
    logic [CODE_WIDTH-1:0] steps_q; // steps still to run after this one

    // divider and step counter; a new start always reloads, so a stale delay is dropped
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            running_q <= 1'b0;
            div_q <= '0;
            steps_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                div_q <= '0;
                steps_q <= delay_code;
                running_q <= ~no_delay;
                done <= no_delay; // zero delay still costs one cycle
            end else if (running_q) begin
                if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
                    div_q <= '0;
                    if (steps_q == '0) begin
                        running_q <= 1'b0;
                        done <= 1'b1;
                    end else begin
                        steps_q <= steps_q - 1'b1;
                    end
                end else begin
                    div_q <= div_q + 1'b1;
                end
            end
        end
    end
endmodule : lvm_delay_timer

//--- lvm_monitor.sv
// led voltage converter control, monitor register and last flash capture
`timescale 1ns/1ps
module lvm_monitor #(
    parameter int DELAY_STEP_CYCLES = lvm_pkg::DELAY_STEP_CYCLES // cycles per delay step
) (
    input wire logic clk, // system clock, 40 MHz
    input wire logic reset, // async reset, active high
    input wire logic [7:0] reg_addr, // register address
    input wire logic reg_wr, // write strobe, one cycle
    input wire logic reg_rd, // read strobe, one cycle
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata, // read data, valid the cycle after reg_rd
    input wire logic flash_active, // flash pulse level
    input wire logic [lvm_pkg::DELAY_CODE_W-1:0] delay_code, // start delay steps minus one
    input wire logic no_delay, // start conversions without delay
    output logic conv_start, // one-cycle start to the analog converter
    input wire logic conv_done, // converter finished, codes valid
    input wire logic [3:0] first_led_voltage, // band code of first led output
    input wire logic [3:0] second_led_voltage, // band code of second led output
    input wire logic fault_flag_write, // pulse, fault flag being written
    input wire logic [3:0] first_source_code, // current flash code, first source
    input wire logic [3:0] second_source_code // current flash code, second source
);
    lvm_pkg::lvm_state_type state_q; // conversion sequencer
    logic flash_q; // previous flash level
    logic manual_q; // manual conversion enable
    logic shutdown_q; // converter shut down
    logic eoc_q; // end of conversion flag
    logic pending_q; // a conversion has been asked for
    logic [3:0] result_q; // latest conversion result
    logic [7:0] capture_q; // last flash capture fields
    logic conv_start_q; // start pulse register
    logic [7:0] rdata_q; // read data register

    logic flash_edge; // flash pulse begins
    logic mon_wr; // write to monitor register
    logic mon_rd; // read of monitor register
    logic done_evt; // conversion completes this cycle
    logic eoc_fall; // done flag is being cleared by a read
    logic manual_edge; // manual mode just turned on
    logic launch; // leave idle and start the delay
    logic timer_done; // start delay expired
    logic [3:0] higher_code; // larger of the two led voltages

    assign flash_edge = flash_active & ~flash_q;
    assign mon_wr = reg_wr && (reg_addr == lvm_pkg::MONITOR_ADDR);
    assign mon_rd = reg_rd && (reg_addr == lvm_pkg::MONITOR_ADDR);
    assign done_evt = (state_q == lvm_pkg::lvm_conv) && conv_done && ~shutdown_q;
    assign eoc_fall = eoc_q & mon_rd & ~done_evt;
    assign manual_edge = mon_wr & reg_wdata[lvm_pkg::MON_MANUAL_BIT] & ~manual_q;
    // no launch while shut down, the request waits for the converter to come back
    assign launch = (state_q == lvm_pkg::lvm_idle) && pending_q && ~shutdown_q;
    // codes are monotonic voltage bands, so the larger code is the higher voltage
    assign higher_code = (first_led_voltage >= second_led_voltage) ?
        first_led_voltage : second_led_voltage;

    assign reg_rdata = rdata_q;
    assign conv_start = conv_start_q;

    // start delay, reloaded on each launch
    lvm_delay_timer #(
        .TICK_CYCLES(DELAY_STEP_CYCLES),
        .CODE_WIDTH(lvm_pkg::DELAY_CODE_W)
    ) u_delay (
        .clk(clk),
        .reset(reset),
        .start(launch),
        .no_delay(no_delay),
        .delay_code(delay_code),
        .done(timer_done)
    );

    // flash level history for edge detection
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flash_q <= 1'b0;
        end else begin
            flash_q <= flash_active;
        end
    end

    // software controlled bits of the monitor register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            manual_q <= lvm_pkg::MANUAL_RST;
            shutdown_q <= lvm_pkg::SHUTDOWN_RST;
        end else if (mon_wr) begin
            manual_q <= reg_wdata[lvm_pkg::MON_MANUAL_BIT];
            shutdown_q <= reg_wdata[lvm_pkg::MON_SHUTDOWN_BIT];
        end
    end

    // conversion request: flash edges always count, manual adds more on top
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pending_q <= 1'b0;
        end else if (flash_edge || manual_edge || (manual_q && eoc_fall)) begin
            pending_q <= 1'b1; // set beats the launch clear
        end else if (launch) begin
            pending_q <= 1'b0;
        end
    end

    // sequencer: idle, delay, conversion
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= lvm_pkg::lvm_idle;
        end else begin
            case (state_q)
                lvm_pkg::lvm_idle: begin
                    if (launch) begin
                        state_q <= lvm_pkg::lvm_wait;
                    end
                end
                lvm_pkg::lvm_wait: begin
                    if (shutdown_q) begin
                        state_q <= lvm_pkg::lvm_idle; // abandon, nothing changes
                    end else if (timer_done) begin
                        state_q <= lvm_pkg::lvm_conv;
                    end
                end
                lvm_pkg::lvm_conv: begin
                    if (shutdown_q || conv_done) begin
                        state_q <= lvm_pkg::lvm_idle;
                    end
                end
                default: begin
                    state_q <= lvm_pkg::lvm_idle;
                end
            endcase
        end
    end

    // start pulse to the converter, suppressed while shut down
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            conv_start_q <= 1'b0;
        end else begin
            conv_start_q <= (state_q == lvm_pkg::lvm_wait) && timer_done && ~shutdown_q;
        end
    end

    // result register holds through shutdown since done_evt needs the converter on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_q <= lvm_pkg::RESULT_RST;
        end else if (done_evt) begin
            result_q <= higher_code;
        end
    end

    // done flag: a completion in the same cycle as a read wins over the clear
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            eoc_q <= lvm_pkg::EOC_RST;
        end else if (done_evt) begin
            eoc_q <= 1'b1;
        end else if (mon_rd) begin
            eoc_q <= 1'b0;
        end
    end

    // capture fields follow the fault flag write timing of the caller
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            capture_q <= lvm_pkg::CAPTURE_RST;
        end else if (fault_flag_write) begin
            capture_q[lvm_pkg::CAP_SECOND_LSB +: lvm_pkg::CODE_W] <= second_source_code;
            capture_q[lvm_pkg::CAP_FIRST_LSB +: lvm_pkg::CODE_W] <= first_source_code;
        end
    end

    // read data, loaded on a read strobe and held until the next one
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata_q <= lvm_pkg::RDATA_IDLE;
        end else if (reg_rd) begin
            case (reg_addr)
                lvm_pkg::MONITOR_ADDR: begin
                    rdata_q <= lvm_pkg::RDATA_IDLE;
                    rdata_q[lvm_pkg::MON_RESULT_LSB +: lvm_pkg::RESULT_W] <= result_q;
                    rdata_q[lvm_pkg::MON_MANUAL_BIT] <= manual_q;
                    rdata_q[lvm_pkg::MON_SHUTDOWN_BIT] <= shutdown_q;
                    rdata_q[lvm_pkg::MON_EOC_BIT] <= eoc_q;
                end
                lvm_pkg::LAST_FLASH_ADDR: begin
                    rdata_q <= capture_q;
                end
                default: begin
                    rdata_q <= lvm_pkg::RDATA_IDLE; // unmapped reads give zero
                end
            endcase
        end
    end

    // checks
    sequence s_conv_finish;
        (state_q == lvm_pkg::lvm_conv) && conv_done && !shutdown_q;
    endsequence

    sequence s_flash_trigger;
        flash_edge && (state_q == lvm_pkg::lvm_idle) && !pending_q && no_delay && !shutdown_q;
    endsequence

    a_result_higher: assert property (@(posedge clk) disable iff (reset)
        s_conv_finish |=> (result_q == $past(higher_code)))
        else $error("result is not the higher led voltage");

    a_eoc_set: assert property (@(posedge clk) disable iff (reset)
        s_conv_finish |=> eoc_q ##1 (eoc_q || $past(mon_rd)))
        else $error("done flag not set after conversion");

    a_read_clears: assert property (@(posedge clk) disable iff (reset)
        (mon_rd && !done_evt) |=> !eoc_q)
        else $error("monitor read did not clear done flag");

    a_shutdown_start: assert property (@(posedge clk) disable iff (reset)
        $past(shutdown_q) |-> !conv_start_q)
        else $error("conversion started while shut down");

    a_flash_launch: assert property (@(posedge clk) disable iff (reset)
        s_flash_trigger ##1 (!shutdown_q [*3]) |-> ##[0:3] conv_start_q)
        else $error("flash start did not launch a conversion");

    a_capture_load: assert property (@(posedge clk) disable iff (reset)
        fault_flag_write |=> (capture_q == {$past(second_source_code), $past(first_source_code)}))
        else $error("capture did not load on fault flag write");

    a_mode_write: assert property (@(posedge clk) disable iff (reset)
        mon_wr |=> (manual_q == $past(reg_wdata[lvm_pkg::MON_MANUAL_BIT]))
            && (result_q == ($past(done_evt) ? $past(higher_code) : $past(result_q))))
        else $error("manual enable not written");

    a_shutdown_hold: assert property (@(posedge clk) disable iff (reset)
        (shutdown_q && !mon_rd) |=> $stable(result_q) && $stable(eoc_q))
        else $error("result or flag changed during shutdown");

    a_read_data: assert property (@(posedge clk) disable iff (reset)
        (mon_rd && !mon_wr) |=>
            (rdata_q[lvm_pkg::MON_RESULT_LSB +: lvm_pkg::RESULT_W] == $past(result_q))
            && !rdata_q[lvm_pkg::MON_SPARE_BIT])
        else $error("monitor read data wrong");

    a_no_delay_skip: assert property (@(posedge clk) disable iff (reset)
        (launch && !no_delay) |=> !timer_done)
        else $error("delay expired too early");
endmodule : lvm_monitor

//--- lvm_conv_model.sv
// behavioural model of the analog converter behind the monitor block
`timescale 1ns/1ps
module lvm_conv_model #(
    parameter int LATENCY = 3 // cycles from the edge that samples start to done
) (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic conv_start, // start pulse from the block
    input wire logic [3:0] first_level, // band code to report, first led
    input wire logic [3:0] second_level, // band code to report, second led
    output logic conv_done, // one-cycle done pulse
    output logic [3:0] first_led_voltage, // first led band code
    output logic [3:0] second_led_voltage // second led band code
);
    int cnt_q; // cycles left in a conversion, 0 when idle

    // codes are only valid with done; otherwise show the inverse so a stale sample shows up
    assign first_led_voltage = conv_done ? first_level : ~first_level;
    assign second_led_voltage = conv_done ? second_level : ~second_level;

    // conversion timer, a new start restarts it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt_q == 1) && !conv_start;
            if (conv_start) begin
                cnt_q <= LATENCY;
            end else if (cnt_q > 0) begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
endmodule : lvm_conv_model

//--- led_voltage_adc_monitor_test.sv
// self-checking testbench of the led voltage monitor block
`timescale 1ns/1ps
module led_voltage_adc_monitor_test;
    localparam logic [7:0] MON = lvm_pkg::MONITOR_ADDR; // monitor register
    localparam logic [7:0] CAP = lvm_pkg::LAST_FLASH_ADDR; // capture register
    logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0; // clock, reset, strobes
    logic flash_active = 1'b0, no_delay = 1'b1, fault_flag_write = 1'b0; // stimulus levels
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata; // register port
    logic [4:0] delay_code = 5'h00; // start delay steps minus one
    logic conv_start, conv_done; // converter link
    logic [3:0] v1, v2, lvl1 = 4'h0, lvl2 = 4'h0, src1 = 4'h0, src2 = 4'h0; // codes
    int fails = 0, checked = 0, cycles = 0, n = 0; // counters

    always #12.5 clk = ~clk;

    lvm_monitor #(.DELAY_STEP_CYCLES(4)) u_dut (.clk(clk), .reset(reset),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .flash_active(flash_active), .delay_code(delay_code),
        .no_delay(no_delay), .conv_start(conv_start), .conv_done(conv_done),
        .first_led_voltage(v1), .second_led_voltage(v2),
        .fault_flag_write(fault_flag_write), .first_source_code(src1),
        .second_source_code(src2));

    lvm_conv_model #(.LATENCY(3)) u_conv (.clk(clk), .reset(reset),
        .conv_start(conv_start), .first_level(lvl1), .second_level(lvl2),
        .conv_done(conv_done), .first_led_voltage(v1), .second_led_voltage(v2));

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read strobe for one cycle; read data stands until the next strobe, so it is
    // compared at the following edge, which keeps every later drive on a clock edge
    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        check(reg_rdata, exp, what);
    endtask : reg_read

    task automatic flash_pulse();
        @(posedge clk);
        flash_active <= 1'b1;
        @(posedge clk);
        flash_active <= 1'b0;
    endtask : flash_pulse

    // counts cycles up to the start pulse, then waits for the converter's answer
    task automatic conversion(input int maxc, output int cnt);
        int k;
        cnt = 0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            cnt++;
        end while (cnt < maxc && conv_start !== 1'b1);
        if (conv_start === 1'b1) begin
            while (k < 20 && conv_done !== 1'b1) begin
                @(posedge clk);
                #1;
                k++;
            end
            repeat (2) @(posedge clk);
        end
    endtask : conversion

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            $display("[ERR] %0t run did not finish", $time);
            test_done();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        reg_read(MON, 8'h00, "monitor reset value");
        reg_read(CAP, 8'h00, "capture reset value");
        reg_read(8'h3A, 8'h00, "unmapped read");
        $display("test reset values done");
        lvl1 <= 4'h5;
        lvl2 <= 4'h9;
        flash_pulse();
        conversion(20, n);
        // the count starts one edge after the flash rise, so that edge is added back
        check(8'(n + 1), 8'h03, "start after flash edge");
        reg_read(MON, 8'h49, "flash result and done flag");
        reg_read(MON, 8'h09, "done flag cleared by read");
        $display("test flash conversion done");
        no_delay <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            delay_code <= (i == 0) ? 5'h00 : 5'h1F;
            flash_pulse();
            conversion(200, n);
            check(8'(n >= (i ? 128 : 4) && n <= (i ? 132 : 8)), 8'h01, "start delay");
            reg_read(MON, 8'h49, "delayed result");
        end
        no_delay <= 1'b1;
        $display("test start delay done");
        lvl1 <= 4'hF;
        lvl2 <= 4'h3;
        reg_write(MON, 8'h10);
        conversion(20, n);
        reg_read(MON, 8'h5F, "manual conversion, top band");
        lvl1 <= 4'h2;
        lvl2 <= 4'h7;
        flash_pulse();
        conversion(20, n);
        reg_read(MON, 8'h57, "flash and manual together");
        conversion(20, n);
        reg_write(MON, 8'h00);
        reg_read(MON, 8'h47, "manual off, done kept");
        $display("test manual mode done");
        lvl1 <= 4'h1;
        lvl2 <= 4'h1;
        reg_write(MON, 8'h20);
        flash_pulse();
        conversion(30, n);
        check(8'(n), 8'h1E, "no start while shut down");
        reg_read(MON, 8'h27, "shutdown keeps result");
        reg_write(MON, 8'h00);
        conversion(20, n);
        reg_read(MON, 8'h41, "pending start after wake");
        $display("test shutdown done");
        src1 <= 4'h3;
        src2 <= 4'hA;
        @(posedge clk);
        fault_flag_write <= 1'b1;
        @(posedge clk);
        fault_flag_write <= 1'b0;
        src1 <= 4'hF;
        src2 <= 4'hF;
        reg_read(CAP, 8'hA3, "capture on fault write");
        reg_write(CAP, 8'h55);
        reg_read(CAP, 8'hA3, "capture held, read only");
        $display("test capture done");
        test_done();
    end
endmodule : led_voltage_adc_monitor_test
